/* rtl/trig_seq.sv */
// Measurement trigger sequencer with APB register access
// ------------------------------------------------------------
// How it works
// (R1) Boot selects the internal reference oscillator; external comes from host connector.
// (R2) Reset command keeps the reference source; only boot forces internal.
// (R3) Averaging mode integrates power over the aperture after a trigger.
// (R4) Abort stops measuring at once; single run then goes idle.
// (R5) Abort in continuous mode goes to waiting for trigger.
// (R6) Single start moves idle to waiting; measuring begins on trigger.
// (R7) Multi-trigger runs revisit waiting; result then presented and idle.
// (R8) Host issues single start only with continuous mode off.
// (R9) Continuous mode skips idle and returns to waiting after each result.
// (R10) Continuous off ends operation into idle; defaults off.
// (R11) After power-on the sequencer is idle and not measuring.
// (R12) Measuring lasts the whole acquisition and ends right at completion.
// (R13) Trigger count one gives one cycle and one result per start.
// (R14) Trigger count above one runs that many cycles per start.
// (R15) Immediate source starts measuring without waiting for a trigger.
// (R16) Internal source triggers from measured power; force trigger also accepted.
// (R17) External source one triggers from the sensor cable pair.
// (R18) External source two triggers from the coaxial trigger input.
// (R19) Hold and bus trigger on force; bus also on common trigger.
// (R20) Level crossing starts measuring after the trigger delay.
// (R21) Dropout timing restarts on every threshold crossing.
// (R22) Hold-off after each accepted trigger ignores further triggers.
// (R23) Trigger rearms only after dropout on the inactive side.
// (R24) Common trigger works only while waiting with bus source.
// (R25) Sync output is high during each measurement.
// (R26) Triggers while idle or measuring are dropped, never queued.
// ------------------------------------------------------------
`timescale 1ns/1ns
module trig_seq (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger inputs and measured power
    input wire logic ext1_trig,
    input wire logic ext2_trig,
    input wire logic [15:0] power,
    // Outputs
    output logic trig_sync,
    output logic ref_ext_sel,
    output logic result_valid
);

    typedef struct packed {
        trig_seq_pkg::cfg_type cfg;
        trig_seq_pkg::seq_state_type state;
        logic single_run;
        logic [13:0] done_cnt;
        logic [31:0] timer;
        logic pending;
        logic [31:0] holdoff_cnt;
        logic [47:0] acc;
        logic [31:0] result;
        logic done;
        logic rvalid;
        logic ext1_d;
        logic ext2_d;
        logic [31:0] rdata;
    } seq_state_struct_type;

    seq_state_struct_type s_r, s_nxt;
    logic level_event;

    // Level-crossing qualifier for the internal source
    trig_qualifier qual (
        .pclk(pclk),
        .presetn(presetn),
        .level(s_r.cfg.level),
        .slope_neg(s_r.cfg.slope_neg),
        .dropout_interval(s_r.cfg.dropout_interval),
        .power(power),
        .event_out(level_event)
    );

    // Decode a register offset, shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ------------------------------------------------------------
    // Sequencer and register file
    // ------------------------------------------------------------
    always_comb begin
        logic wr;
        logic rd;
        trig_seq_pkg::cmd_type cmd;
        logic trig_raw;
        logic trig_ok;
        logic finish;
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        s_nxt = s_r;
        s_nxt.ext1_d = ext1_trig;
        s_nxt.ext2_d = ext2_trig;
        s_nxt.done = 1'b0;
        cmd = '0;
        // Register writes
        if (wr) begin
            if (hit(paddr, trig_seq_pkg::OFS_CTRL)) begin
                s_nxt.cfg.cont = pwdata[trig_seq_pkg::CTRL_CONT_BIT];
                cmd.cont_off = s_r.cfg.cont && !pwdata[trig_seq_pkg::CTRL_CONT_BIT];
                s_nxt.cfg.src = trig_seq_pkg::trig_src_type'(
                    pwdata[trig_seq_pkg::CTRL_SRC_LSB +: 3]);
                s_nxt.cfg.slope_neg = pwdata[trig_seq_pkg::CTRL_SLOPE_BIT];
                s_nxt.cfg.ref_ext = pwdata[trig_seq_pkg::CTRL_REF_BIT];
            end
            if (hit(paddr, trig_seq_pkg::OFS_CMD)) begin
                cmd.start = pwdata[trig_seq_pkg::CMD_START_BIT];
                cmd.abort = pwdata[trig_seq_pkg::CMD_ABORT_BIT];
                cmd.force_trig = pwdata[trig_seq_pkg::CMD_FORCE_BIT];
                cmd.bus_trig = pwdata[trig_seq_pkg::CMD_BUS_BIT];
            end
            if (hit(paddr, trig_seq_pkg::OFS_COUNT) && pwdata[13:0] != 14'h0000) begin
                s_nxt.cfg.count = pwdata[13:0];
            end
            if (hit(paddr, trig_seq_pkg::OFS_DELAY)) begin
                s_nxt.cfg.delay = pwdata;
            end
            if (hit(paddr, trig_seq_pkg::OFS_DROPOUT)) begin
                s_nxt.cfg.dropout_interval = pwdata;
            end
            if (hit(paddr, trig_seq_pkg::OFS_HOLDOFF)) begin
                s_nxt.cfg.holdoff = pwdata;
            end
            if (hit(paddr, trig_seq_pkg::OFS_APERTURE) && pwdata != 32'h0000_0000) begin
                s_nxt.cfg.aperture = pwdata;
            end
            if (hit(paddr, trig_seq_pkg::OFS_LEVEL)) begin
                s_nxt.cfg.level = pwdata[15:0];
            end
        end
        // Device reset command restores defaults but keeps the reference source and the slope setting
        if (wr && hit(paddr, trig_seq_pkg::OFS_CMD) && pwdata[trig_seq_pkg::CMD_RESET_BIT]) begin
            s_nxt.cfg.cont = 1'b0;
            s_nxt.cfg.src = trig_seq_pkg::SRC_IMMEDIATE;
            s_nxt.cfg.count = trig_seq_pkg::COUNT_RST;
            s_nxt.cfg.delay = trig_seq_pkg::TIME_RST;
            s_nxt.cfg.dropout_interval = trig_seq_pkg::TIME_RST;
            s_nxt.cfg.holdoff = trig_seq_pkg::TIME_RST;
            s_nxt.cfg.aperture = trig_seq_pkg::APERTURE_RST;
            s_nxt.cfg.level = trig_seq_pkg::LEVEL_RST;
            s_nxt.cfg.ref_ext = s_r.cfg.ref_ext; // see R2
            cmd.cont_off = s_r.cfg.cont;
        end

        // Trigger source selection
        case (s_r.cfg.src)
            trig_seq_pkg::SRC_HOLD: trig_raw = cmd.force_trig; // see R19
            trig_seq_pkg::SRC_IMMEDIATE: trig_raw = 1'b1; // see R15
            trig_seq_pkg::SRC_INTERNAL: trig_raw = level_event || cmd.force_trig; // see R16
            trig_seq_pkg::SRC_EXT1: trig_raw = (ext1_trig && !s_r.ext1_d) || cmd.force_trig; // see R17
            trig_seq_pkg::SRC_EXT2: trig_raw = (ext2_trig && !s_r.ext2_d) || cmd.force_trig; // see R18
            trig_seq_pkg::SRC_BUS: trig_raw = cmd.force_trig || cmd.bus_trig; // see R19, see R24
            default: trig_raw = 1'b0;
        endcase
        // Triggers outside waiting state or inside hold-off are dropped
        trig_ok = trig_raw && s_r.state == trig_seq_pkg::ST_WAIT && !s_r.pending
            && s_r.holdoff_cnt == 32'h0000_0000; // see R22, see R26

        if (s_r.holdoff_cnt != 32'h0000_0000) begin
            s_nxt.holdoff_cnt = s_r.holdoff_cnt - 32'h0000_0001;
        end
        finish = 1'b0;

        case (s_r.state)
            trig_seq_pkg::ST_IDLE: begin
                if (cmd.start) begin
                    s_nxt.state = trig_seq_pkg::ST_WAIT; // see R6
                    s_nxt.single_run = 1'b1;
                    s_nxt.done_cnt = 14'h0000;
                end else if (wr && hit(paddr, trig_seq_pkg::OFS_CTRL)
                        && pwdata[trig_seq_pkg::CTRL_CONT_BIT] && !s_r.cfg.cont) begin
                    s_nxt.state = trig_seq_pkg::ST_WAIT;
                    s_nxt.single_run = 1'b0;
                end
            end
            trig_seq_pkg::ST_WAIT: begin
                if (trig_ok) begin
                    s_nxt.pending = 1'b1;
                    s_nxt.timer = s_r.cfg.delay; // see R20
                    s_nxt.holdoff_cnt = s_r.cfg.holdoff; // see R22
                end else if (s_r.pending) begin
                    if (s_r.timer == 32'h0000_0000) begin
                        s_nxt.pending = 1'b0;
                        s_nxt.state = trig_seq_pkg::ST_MEASURE;
                        s_nxt.timer = s_r.cfg.aperture;
                        s_nxt.acc = 48'h0000_0000_0000;
                    end else begin
                        s_nxt.timer = s_r.timer - 32'h0000_0001;
                    end
                end
            end
            trig_seq_pkg::ST_MEASURE: begin
                // Integrate power over the aperture interval (see R3)
                s_nxt.acc = s_r.acc + {32'h0000_0000, power};
                if (s_r.timer <= 32'h0000_0001) begin
                    finish = 1'b1; // see R12
                end else begin
                    s_nxt.timer = s_r.timer - 32'h0000_0001;
                end
            end
            default: s_nxt.state = trig_seq_pkg::ST_IDLE;
        endcase

        // Completion: present result, count triggers, pick next state
        if (finish) begin
            s_nxt.result = s_r.acc[31:0] + {16'h0000, power};
            s_nxt.done = 1'b1;
            s_nxt.rvalid = 1'b1;
            s_nxt.done_cnt = s_r.done_cnt + 14'h0001;
            if (s_r.cfg.cont) begin
                s_nxt.state = trig_seq_pkg::ST_WAIT; // see R9
            end else if (s_r.done_cnt + 14'h0001 >= s_r.cfg.count) begin
                s_nxt.state = trig_seq_pkg::ST_IDLE; // see R7, see R13
            end else begin
                s_nxt.state = trig_seq_pkg::ST_WAIT; // see R14
            end
        end

        // Abort drops any delay in progress and picks the state by mode
        if (cmd.abort && s_r.state != trig_seq_pkg::ST_IDLE) begin
            s_nxt.pending = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.state = s_r.cfg.cont ? trig_seq_pkg::ST_WAIT // see R5
                                       : trig_seq_pkg::ST_IDLE; // see R4
        end
        if (cmd.cont_off) begin
            s_nxt.pending = 1'b0;
            s_nxt.state = trig_seq_pkg::ST_IDLE; // see R10
        end

        // Read data captured in the setup phase so prdata comes from a flop
        if (rd) begin
            s_nxt.rdata = 32'h0000_0000;
            case (paddr)
                trig_seq_pkg::OFS_CTRL: begin
                    s_nxt.rdata[trig_seq_pkg::CTRL_CONT_BIT] = s_r.cfg.cont;
                    s_nxt.rdata[trig_seq_pkg::CTRL_SRC_LSB +: 3] = s_r.cfg.src;
                    s_nxt.rdata[trig_seq_pkg::CTRL_SLOPE_BIT] = s_r.cfg.slope_neg;
                    s_nxt.rdata[trig_seq_pkg::CTRL_REF_BIT] = s_r.cfg.ref_ext;
                end
                trig_seq_pkg::OFS_COUNT: s_nxt.rdata[13:0] = s_r.cfg.count;
                trig_seq_pkg::OFS_DELAY: s_nxt.rdata = s_r.cfg.delay;
                trig_seq_pkg::OFS_DROPOUT: s_nxt.rdata = s_r.cfg.dropout_interval;
                trig_seq_pkg::OFS_HOLDOFF: s_nxt.rdata = s_r.cfg.holdoff;
                trig_seq_pkg::OFS_APERTURE: s_nxt.rdata = s_r.cfg.aperture;
                trig_seq_pkg::OFS_LEVEL: s_nxt.rdata[15:0] = s_r.cfg.level;
                trig_seq_pkg::OFS_STATUS: begin
                    s_nxt.rdata[trig_seq_pkg::STAT_STATE_LSB +: 2] = s_r.state;
                    s_nxt.rdata[trig_seq_pkg::STAT_DONE_BIT] = s_r.rvalid;
                    s_nxt.rdata[trig_seq_pkg::STAT_SYNC_BIT] =
                        s_r.state == trig_seq_pkg::ST_MEASURE;
                    s_nxt.rdata[trig_seq_pkg::STAT_REF_BIT] = s_r.cfg.ref_ext;
                end
                trig_seq_pkg::OFS_RESULT: s_nxt.rdata = s_r.result;
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
            // Reading the result clears the flag unless a new result lands now
            if (hit(paddr, trig_seq_pkg::OFS_RESULT) && !finish) begin
                s_nxt.rvalid = 1'b0;
            end
        end
    end

    // Boot forces the internal reference and idle state (see R1, see R11)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.cfg.src <= trig_seq_pkg::SRC_IMMEDIATE;
            s_r.cfg.count <= trig_seq_pkg::COUNT_RST;
            s_r.cfg.aperture <= trig_seq_pkg::APERTURE_RST;
            s_r.state <= trig_seq_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states; unmapped reads return zero without error
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = s_r.rdata;
    assign trig_sync = s_r.state == trig_seq_pkg::ST_MEASURE; // see R25
    assign ref_ext_sel = s_r.cfg.ref_ext;
    assign result_valid = s_r.rvalid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_sync_measure: assert property (@(posedge pclk) disable iff (!presetn) // see R25
        s_r.state == trig_seq_pkg::ST_WAIT && s_r.pending && s_r.timer == 32'h0000_0000
            && !(psel && penable) |=> trig_sync)
        else $error("sync not raised as measuring began");
    chk_abort_single: assert property (@(posedge pclk) disable iff (!presetn) // see R4
        (wr_abort() && !s_r.cfg.cont && !wr_ctrl()) |=> s_r.state == trig_seq_pkg::ST_IDLE)
        else $error("abort in single run did not go idle");
    chk_abort_cont: assert property (@(posedge pclk) disable iff (!presetn) // see R5
        (wr_abort() && s_r.cfg.cont && !wr_ctrl() && s_r.state != trig_seq_pkg::ST_IDLE)
        |=> s_r.state == trig_seq_pkg::ST_WAIT)
        else $error("abort in continuous mode did not wait");
    chk_start_waits: assert property (@(posedge pclk) disable iff (!presetn) // see R6
        (s_r.state == trig_seq_pkg::ST_IDLE && wr_cmd_bit(trig_seq_pkg::CMD_START_BIT))
        |=> s_r.state == trig_seq_pkg::ST_WAIT)
        else $error("start did not enter waiting");
    chk_cont_restart: assert property (@(posedge pclk) disable iff (!presetn) // see R9
        (s_r.done && s_r.cfg.cont) |-> s_r.state == trig_seq_pkg::ST_WAIT
            || $past(psel && penable))
        else $error("continuous mode did not re-arm");
    chk_cont_off_idle: assert property (@(posedge pclk) disable iff (!presetn) // see R10
        (wr_ctrl() && s_r.cfg.cont && !pwdata[trig_seq_pkg::CTRL_CONT_BIT])
        |=> s_r.state == trig_seq_pkg::ST_IDLE)
        else $error("continuous off did not go idle");
    chk_measure_len: assert property (@(posedge pclk) disable iff (!presetn) // see R12
        $rose(trig_sync) && s_r.timer == 32'h0000_0003 && !(psel && penable)
        |=> trig_sync ##1 (trig_sync || $past(psel && penable)) ##1 !trig_sync)
        else $error("measurement length wrong");
    chk_idle_trigger: assert property (@(posedge pclk) disable iff (!presetn) // see R26
        s_r.state == trig_seq_pkg::ST_IDLE && !(psel && penable) |=> !trig_sync)
        else $error("measurement started from idle");

    function automatic logic wr_ctrl();
        return psel && penable && pwrite && paddr == trig_seq_pkg::OFS_CTRL;
    endfunction
    function automatic logic wr_cmd_bit(input int b);
        return psel && penable && pwrite && paddr == trig_seq_pkg::OFS_CMD && pwdata[b];
    endfunction
    function automatic logic wr_abort();
        return wr_cmd_bit(trig_seq_pkg::CMD_ABORT_BIT);
    endfunction

endmodule

/* rtl/trig_seq_pkg.sv */
// Package with register map, field layout, enums and state types of the trigger sequencer
package trig_seq_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0C;
    localparam logic [7:0] OFS_DROPOUT = 8'h10;
    localparam logic [7:0] OFS_HOLDOFF = 8'h14;
    localparam logic [7:0] OFS_APERTURE = 8'h18;
    localparam logic [7:0] OFS_LEVEL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_RESULT = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // CTRL register
    localparam int CTRL_CONT_BIT = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_SLOPE_BIT = 8;
    localparam int CTRL_REF_BIT = 12;
    // CMD register (write-one strobes)
    localparam int CMD_START_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;
    localparam int CMD_FORCE_BIT = 2;
    localparam int CMD_BUS_BIT = 3;
    localparam int CMD_RESET_BIT = 4;
    // STATUS register
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DONE_BIT = 4;
    localparam int STAT_SYNC_BIT = 5;
    localparam int STAT_REF_BIT = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [13:0] COUNT_RST = 14'h0001;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;
    localparam logic [31:0] APERTURE_RST = 32'h0000_0064;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h0000;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_HOLD, SRC_IMMEDIATE, SRC_INTERNAL, SRC_EXT1, SRC_EXT2, SRC_BUS
    } trig_src_type;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT, ST_MEASURE
    } seq_state_type;

    // Register file contents
    typedef struct packed {
        logic cont;
        trig_src_type src;
        logic slope_neg;
        logic ref_ext;
        logic [13:0] count;
        logic [31:0] delay;
        logic [31:0] dropout_interval;
        logic [31:0] holdoff;
        logic [31:0] aperture;
        logic [15:0] level;
    } cfg_type;

    // One-cycle command strobes to the sequencer core
    typedef struct packed {
        logic start;
        logic abort;
        logic force_trig;
        logic bus_trig;
        logic cont_off;
    } cmd_type;

endpackage

/* rtl/trig_qualifier.sv */
// Level-crossing trigger qualifier with dropout interval
`timescale 1ns/1ns
module trig_qualifier (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire logic [15:0] level,
    input wire logic slope_neg,
    input wire logic [31:0] dropout_interval,
    // Measured power sample
    input wire logic [15:0] power,
    // Qualified crossing event
    output logic event_out
);

    typedef struct packed {
        logic above;
        logic [31:0] quiet;
        logic armed;
        logic ev;
    } qual_state_type;

    qual_state_type s_r, s_nxt;

    // ------------------------------------------------------------
    // Crossing detection
    // ------------------------------------------------------------
    // Any threshold crossing restarts the dropout timer (see R21); the trigger
    // arms only once the signal sat on the inactive side long enough (see R23)
    always_comb begin
        logic now_above;
        logic inactive;
        now_above = (power > level);
        inactive = slope_neg ? now_above : !now_above;
        s_nxt = s_r;
        s_nxt.ev = 1'b0;
        s_nxt.above = now_above;
        if (now_above != s_r.above) begin
            s_nxt.quiet = 32'h0000_0000; // see R21
            if (s_r.armed && !inactive) begin
                s_nxt.ev = 1'b1; // see R20
                s_nxt.armed = 1'b0;
            end
        end else if (inactive) begin
            if (s_r.quiet >= dropout_interval) begin
                s_nxt.armed = 1'b1; // see R23
            end else begin
                s_nxt.quiet = s_r.quiet + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign event_out = s_r.ev;

endmodule

/* testbench/host_model.sv */
// Host controller model: APB master issuing remote measurement commands
`timescale 1ns/1ns
module host_model (
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    // Bus idle from time zero so no request leaks out during reset
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer, held until pready is sampled high
    // Callers send a start only while continuous mode is off
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking testbench of the trigger sequencer
`timescale 1ns/1ns
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, trig_sync, ref_ext_sel, result_valid;
    logic ext1_trig = 1'b0;
    logic ext2_trig = 1'b0;
    logic [15:0] power = 16'h0005;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    // Clock of 20 ns
    always #10 pclk = ~pclk;

    trig_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext1_trig(ext1_trig), .ext2_trig(ext2_trig), .power(power),
        .trig_sync(trig_sync), .ref_ext_sel(ref_ext_sel), .result_valid(result_valid));
    host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // A hang is cut short well past the expected run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdata);
    endtask
    task automatic rd_state(input logic [1:0] exp);
        host.xfer(1'b0, trig_seq_pkg::OFS_STATUS, 32'h0000_0000, rdata);
        cmp("state", {30'h0000_0000, exp}, {30'h0000_0000, rdata[1:0]});
        cmp("slave error", 32'h0, {31'h0, pslverr});
    endtask
    task automatic wait_sync();
        int i;
        i = 0;
        while (trig_sync !== 1'b1 && i < 60) begin
            @(posedge pclk);
            #1 i++;
        end
    endtask
    // Length of one measurement seen on the sync output
    task automatic measure(input int exp_len);
        int n;
        n = 0;
        wait_sync();
        while (trig_sync === 1'b1 && n < 60) begin
            @(posedge pclk);
            #1 n++;
        end
        cmp("measure length", 32'(exp_len), 32'(n));
    endtask
    // Trigger kinds: 0 force command, 1 cable pair, 2 coax, 3 common bus command, 4 level crossing
    task automatic fire(input int k);
        if (k == 0) wr(trig_seq_pkg::OFS_CMD, 32'h0000_0004);
        if (k == 3) wr(trig_seq_pkg::OFS_CMD, 32'h0000_0008);
        if (k == 1 || k == 2 || k == 4) begin
            @(posedge pclk);
            ext1_trig <= (k == 1);
            ext2_trig <= (k == 2);
            power <= (k == 4) ? 16'h0009 : 16'h0005;
            @(posedge pclk);
            ext1_trig <= 1'b0;
            ext2_trig <= 1'b0;
            power <= 16'h0005;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic single_runs();
        wr(trig_seq_pkg::OFS_APERTURE, 32'h0000_0003);
        wr(trig_seq_pkg::OFS_CTRL, 32'h0000_0010);
        for (int r = 0; r < 2; r++) begin
            wr(trig_seq_pkg::OFS_CMD, 32'h0000_0001);
            measure(3);
            cmp("result valid", 32'h1, {31'h0, result_valid});
            host.xfer(1'b0, trig_seq_pkg::OFS_RESULT, 32'h0000_0000, rdata);
            cmp("result", 32'h0000_000F, rdata);
            rd_state(2'h0);
        end
        wr(trig_seq_pkg::OFS_COUNT, 32'h0000_0002);
        wr(trig_seq_pkg::OFS_CMD, 32'h0000_0001);
        measure(3);
        measure(3);
        rd_state(2'h0);
        wr(trig_seq_pkg::OFS_COUNT, 32'h0000_0001);
    endtask
    // Every source except immediate with its own trigger; an early trigger in idle must not be kept
    task automatic source_runs();
        trig_seq_pkg::trig_src_type srcs [5];
        int kinds [5];
        srcs = '{trig_seq_pkg::SRC_HOLD, trig_seq_pkg::SRC_INTERNAL, trig_seq_pkg::SRC_EXT1,
                 trig_seq_pkg::SRC_EXT2, trig_seq_pkg::SRC_BUS};
        kinds = '{0, 4, 1, 2, 3};
        wr(trig_seq_pkg::OFS_LEVEL, 32'h0000_0008);
        for (int s = 0; s < 5; s++) begin
            wr(trig_seq_pkg::OFS_CTRL, {25'h0000000, srcs[s], 4'h0});
            fire(kinds[s]);
            wr(trig_seq_pkg::OFS_CMD, 32'h0000_0001);
            if (s == 0) wr(trig_seq_pkg::OFS_CMD, 32'h0000_0008);
            rd_state(2'h1);
            fire(kinds[s]);
            measure(3);
            rd_state(2'h0);
        end
    endtask
    task automatic abort_runs();
        wr(trig_seq_pkg::OFS_APERTURE, 32'h0000_0028);
        wr(trig_seq_pkg::OFS_CTRL, 32'h0000_0010);
        wr(trig_seq_pkg::OFS_CMD, 32'h0000_0001);
        wait_sync();
        wr(trig_seq_pkg::OFS_CMD, 32'h0000_0002);
        rd_state(2'h0);
        cmp("sync after abort", 32'h0, {31'h0, trig_sync});
        wr(trig_seq_pkg::OFS_CTRL, 32'h0000_0001);
        rd_state(2'h1);
        fire(0);
        wait_sync();
        wr(trig_seq_pkg::OFS_CMD, 32'h0000_0002);
        rd_state(2'h1);
        wr(trig_seq_pkg::OFS_APERTURE, 32'h0000_0003);
        fire(0);
        measure(3);
        rd_state(2'h1);
        wr(trig_seq_pkg::OFS_CTRL, 32'h0000_0000);
        rd_state(2'h0);
    endtask

    // Main sequence: reset for 3 cycles, then the scenarios
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1 cmp("ref select", 32'h0, {31'h0, ref_ext_sel});
        cmp("sync at reset", 32'h0, {31'h0, trig_sync});
        rd_state(2'h0);
        single_runs();
        source_runs();
        abort_runs();
        wr(trig_seq_pkg::OFS_CTRL, 32'h0000_1000);
        wr(trig_seq_pkg::OFS_CMD, 32'h0000_0010);
        @(posedge pclk);
        #1 cmp("ref kept", 32'h1, {31'h0, ref_ext_sel});
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1 cmp("ref at boot", 32'h0, {31'h0, ref_ext_sel});
        end_of_test();
    end
endmodule
